// [verilog/lfc_pkg.sv]
// Constants and types shared by the flash mode and fault supervisor.
package lfc_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_REV = 8'h00;
	localparam logic [7:0] ADDR_INPUT_VOLTAGE_FLASH_MONITOR = 8'h01;
	localparam logic [7:0] ADDR_NTC = 8'h02;
	localparam logic [7:0] ADDR_CFG = 8'h07;
	localparam logic [7:0] ADDR_FEAT = 8'h08;
	localparam logic [7:0] ADDR_EN = 8'h0A;
	localparam logic [7:0] ADDR_FLAGS = 8'h0B;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [1:0] FILT_RST = 2'h0;
	localparam logic [7:0] INPUT_VOLTAGE_FLASH_MONITOR_RST = 8'h80;
	localparam logic [7:0] NTC_RST = 8'h12;
	localparam logic [7:0] CFG_RST = 8'h78;
	localparam logic [7:0] FEAT_RST = 8'h1F;
	localparam logic [7:0] EN_RST = 8'h40;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int REV_FILT_LSB = 3;
	localparam int INPUT_VOLTAGE_FLASH_MONITOR_THR_LSB = 0;
	localparam int INPUT_VOLTAGE_FLASH_MONITOR_HYST_LSB = 3;
	localparam int INPUT_MONITOR_MODE_LSB = 5;
	localparam int INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE = 7;
	localparam int NTC_THR_LSB = 0;
	localparam int NTC_CUR_LSB = 3;
	localparam int CFG_TX_POL = 3;
	localparam int CFG_TX_TORCH = 4;
	localparam int CFG_NTC_TORCH = 5;
	localparam int CFG_STROBE_LVL = 7;
	localparam int FEAT_TO_LSB = 0;
	localparam int FEAT_CL_LSB = 3;
	localparam int EN_PRECHG = 2;
	localparam int EN_NTC = 3;
	localparam int EN_TEN = 4;
	localparam int EN_STROBE = 5;
	localparam int EN_TX = 6;
	localparam logic [7:0] EN_LOCK_MASK = 8'h17;
	localparam int FLG_TO = 0;
	localparam int FLG_TSD = 1;
	localparam int FLG_LED = 2;
	localparam int FLG_NTC = 3;
	localparam int FLG_TX = 4;
	localparam int FLG_UVLO = 5;
	localparam int FLG_INPUT_VOLTAGE_FLASH_MONITOR = 6;
	localparam logic [7:0] FLG_LOCK_MASK = 8'h2E;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_KHZ = 25000;
	localparam int CLK_MHZ = CLK_KHZ / 1000;
	localparam int TO_STEP_MS = 100;
	localparam int TO_STEP_CYC = TO_STEP_MS * CLK_KHZ;
	localparam int LED_DLY_US = 256;
	localparam int LED_DLY_CYC = LED_DLY_US * CLK_MHZ;
	localparam int VOUT_DLY_US = 2048;
	localparam int VOUT_DLY_CYC = VOUT_DLY_US * CLK_MHZ;
	localparam int FILT_BASE_US = 100;
	localparam int FILT_BASE_CYC = FILT_BASE_US * CLK_MHZ;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_STBY = 2'b00,
		MODE_IND = 2'b01,
		MODE_TORCH = 2'b10,
		MODE_FLASH = 2'b11
	} lfc_mode_t;

	typedef enum logic [1:0] {
		LVL_OFF = 2'b00,
		LVL_TORCH = 2'b01,
		LVL_FLASH = 2'b10,
		LVL_IND = 2'b11
	} lfc_level_t;

	typedef enum logic [1:0] {
		INPUT_VOLTAGE_FLASH_MONITOR_REPORT = 2'b00,
		INPUT_VOLTAGE_FLASH_MONITOR_STOP_HOLD = 2'b01,
		INPUT_VOLTAGE_FLASH_MONITOR_ADJ_DOWN = 2'b10,
		INPUT_VOLTAGE_FLASH_MONITOR_ADJ_UPDOWN = 2'b11
	} lfc_input_monitor_mode_t;

endpackage

// [verilog/lfc_timer.sv]
// Run-while-enabled cycle counter with a programmable terminal count.
`timescale 1ns/1ps
module lfc_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Control
	input wire logic run,
	input wire logic [W-1:0] limit,
	// Status
	output logic done
);

	logic [W-1:0] cnt_r;

	// Restarts from zero whenever run drops, saturates at the limit
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cnt_r <= '0;
		end else if (!run) begin
			cnt_r <= '0;
		end else if (cnt_r != limit) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign done = run && (cnt_r == limit);

endmodule

// [verilog/lfc_input_voltage_flash_monitor.sv]
// Input voltage flash monitor: ramp hold and step requests per mode.
`timescale 1ns/1ps
module lfc_input_voltage_flash_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Settings and state
	input wire lfc_pkg::lfc_input_monitor_mode_t mode,
	input wire logic flash_act,
	input wire logic ramp_busy,
	// Comparators
	input wire logic below_low,
	input wire logic above_rec,
	input wire logic filt_done,
	// Requests
	output logic low_evt,
	output logic ramp_hold,
	output logic ramp_down,
	output logic ramp_up
);

	logic below_q_r;
	logic cut;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			below_q_r <= 1'b0;
		end else begin
			below_q_r <= below_low;
		end
	end

	// Crossing reported in every mode
	assign low_evt = below_low && !below_q_r;
	// Reduction only after the filter has run out
	assign cut = flash_act && below_low && filt_done;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ramp_hold <= 1'b0;
			ramp_down <= 1'b0;
			ramp_up <= 1'b0;
		end else begin
			ramp_hold <= 1'b0;
			ramp_down <= 1'b0;
			ramp_up <= 1'b0;
			case (mode)
				lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_STOP_HOLD: begin
					ramp_hold <= cut && ramp_busy;
				end
				lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_ADJ_DOWN: begin
					ramp_down <= cut;
				end
				lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_ADJ_UPDOWN: begin
					ramp_down <= cut;
					ramp_up <= flash_act && above_rec && !below_low;
				end
				default: begin
					ramp_hold <= 1'b0;
				end
			endcase
		end
	end

endmodule

// [verilog/lfc_top.sv]
// Flash driver mode control, sync handling and fault supervision.
`timescale 1ns/1ps
module lfc_top #(
	parameter int TO_STEP_CYC = lfc_pkg::TO_STEP_CYC,
	parameter int LED_DLY_CYC = lfc_pkg::LED_DLY_CYC,
	parameter int VOUT_DLY_CYC = lfc_pkg::VOUT_DLY_CYC,
	parameter int FILT_BASE_CYC = lfc_pkg::FILT_BASE_CYC,
	// Revision code value is arbitrary
	parameter logic [2:0] REV_ID = 3'h5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_rd_end,
	output logic [7:0] reg_rdata,
	// Logic inputs
	input wire logic strobe_in,
	input wire logic torch_in,
	input wire logic tx_in,
	// Comparator results
	input wire logic vin_below_low,
	input wire logic vin_above_recovery,
	input wire logic vin_uvlo,
	input wire logic die_hot,
	input wire logic ntc_below,
	input wire logic ovp_trip,
	input wire logic curlim_trip,
	input wire logic vout_low,
	input wire logic led_low,
	input wire logic ramp_busy,
	// LED and monitor control
	output lfc_pkg::lfc_level_t led_level,
	output logic ramp_hold,
	output logic ramp_down,
	output logic ramp_up,
	output logic ntc_power,
	output logic standby,
	// Converter control
	output logic conv_en,
	output logic nfet_off,
	output logic charge_end,
	output logic pfet_cs,
	// Analog settings
	output logic [2:0] input_voltage_flash_monitor_low_sel,
	output logic [1:0] input_voltage_flash_monitor_hyst_sel,
	output logic [2:0] ntc_thr_sel,
	output logic [1:0] ntc_cur_sel,
	output logic [1:0] curlim_sel
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [1:0] filt_sel_r;
	logic [7:0] input_voltage_flash_monitor_r, ntc_r, cfg_r, feat_r, en_r, flags_r;
	logic [7:0] rdata_r, flag_set;
	logic lock_r, rd_pend_r, strobe_q_r, strobe_arm_r;
	lfc_pkg::lfc_level_t level_r, level_nxt;
	lfc_pkg::lfc_mode_t mode;
	logic flash_act, to_done, led_dg, vout_dg, filt_done, tx_act;
	logic torch_pin_on, clr, lock_set, input_voltage_flash_monitor_evt, ntc_trip, led_on;
	logic uvlo_trip, led_fault, wr_en;
	logic [24:0] to_lim;
	logic [15:0] filt_lim;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		return reg_wr && (a == t);
	endfunction

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			filt_sel_r <= lfc_pkg::FILT_RST;
			input_voltage_flash_monitor_r <= lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_RST;
			ntc_r <= lfc_pkg::NTC_RST;
			cfg_r <= lfc_pkg::CFG_RST;
			feat_r <= lfc_pkg::FEAT_RST;
		end else begin
			if (hit(reg_addr, lfc_pkg::ADDR_REV)) begin
				filt_sel_r <= reg_wdata[lfc_pkg::REV_FILT_LSB +: 2];
			end
			if (hit(reg_addr, lfc_pkg::ADDR_INPUT_VOLTAGE_FLASH_MONITOR)) begin
				input_voltage_flash_monitor_r <= reg_wdata;
			end
			if (hit(reg_addr, lfc_pkg::ADDR_NTC)) begin
				ntc_r <= reg_wdata;
			end
			if (hit(reg_addr, lfc_pkg::ADDR_CFG)) begin
				cfg_r <= reg_wdata;
			end
			if (hit(reg_addr, lfc_pkg::ADDR_FEAT)) begin
				feat_r <= reg_wdata;
			end
		end
	end

	assign wr_en = reg_wr && (reg_addr == lfc_pkg::ADDR_EN);

	// Locked bits read zero and refuse writes until the flags are read
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			en_r <= lfc_pkg::EN_RST;
		end else begin
			if (wr_en) begin
				en_r <= reg_wdata & ~((lock_r || lock_set) ?
					lfc_pkg::EN_LOCK_MASK : 8'h00);
			end else if (lock_set) begin
				en_r <= en_r & ~lfc_pkg::EN_LOCK_MASK;
			end
			if (to_done) begin
				en_r[1:0] <= lfc_pkg::MODE_STBY;
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				lfc_pkg::ADDR_REV: rdata_r <= {3'h0, filt_sel_r, REV_ID};
				lfc_pkg::ADDR_INPUT_VOLTAGE_FLASH_MONITOR: rdata_r <= input_voltage_flash_monitor_r;
				lfc_pkg::ADDR_NTC: rdata_r <= ntc_r;
				lfc_pkg::ADDR_CFG: rdata_r <= cfg_r;
				lfc_pkg::ADDR_FEAT: rdata_r <= feat_r;
				lfc_pkg::ADDR_EN: rdata_r <= en_r;
				lfc_pkg::ADDR_FLAGS: rdata_r <= flags_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_r;

	// Flags clear when the read transfer of the flags register ends
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rd_pend_r <= 1'b0;
		end else if (reg_rd) begin
			rd_pend_r <= (reg_addr == lfc_pkg::ADDR_FLAGS);
		end else if (reg_rd_end) begin
			rd_pend_r <= 1'b0;
		end
	end

	assign clr = reg_rd_end && rd_pend_r;

	// ****************************************************************
	// Flash activity and sync input
	// ****************************************************************
	assign mode = lfc_pkg::lfc_mode_t'(en_r[1:0]);
	assign tx_act = en_r[lfc_pkg::EN_TX] &&
		(tx_in == cfg_r[lfc_pkg::CFG_TX_POL]);
	assign torch_pin_on = en_r[lfc_pkg::EN_TEN] && torch_in;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			strobe_q_r <= 1'b0;
			strobe_arm_r <= 1'b0;
		end else begin
			strobe_q_r <= strobe_in;
			if (mode != lfc_pkg::MODE_FLASH) begin
				strobe_arm_r <= 1'b0;
			end else if (strobe_in && !strobe_q_r) begin
				strobe_arm_r <= 1'b1;
			end
		end
	end

	// Register start, or trigger pin by edge or by level
	assign flash_act = (mode == lfc_pkg::MODE_FLASH) && !lock_r &&
		(!en_r[lfc_pkg::EN_STROBE] ||
		(cfg_r[lfc_pkg::CFG_STROBE_LVL] ? strobe_in : strobe_arm_r));

	assign to_lim = 25'(TO_STEP_CYC *
		(int'(feat_r[lfc_pkg::FEAT_TO_LSB +: 3]) + 1));

	lfc_timer #(.W(25)) u_flash_to (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(flash_act),
		.limit(to_lim),
		.done(to_done)
	);

	// ****************************************************************
	// LED level selection
	// ****************************************************************
	always_comb begin
		level_nxt = lfc_pkg::LVL_OFF;
		if (!lock_r) begin
			case (mode)
				lfc_pkg::MODE_FLASH: begin
					if (flash_act && !to_done) begin
						if (ntc_trip) begin
							level_nxt = cfg_r[lfc_pkg::CFG_NTC_TORCH] ?
								lfc_pkg::LVL_TORCH : lfc_pkg::LVL_OFF;
						end else if (tx_act) begin
							level_nxt = cfg_r[lfc_pkg::CFG_TX_TORCH] ?
								lfc_pkg::LVL_TORCH : lfc_pkg::LVL_OFF;
						end else begin
							level_nxt = lfc_pkg::LVL_FLASH;
						end
					end else if (torch_pin_on) begin
						level_nxt = lfc_pkg::LVL_TORCH;
					end
				end
				lfc_pkg::MODE_TORCH: level_nxt = lfc_pkg::LVL_TORCH;
				lfc_pkg::MODE_IND: level_nxt = lfc_pkg::LVL_IND;
				default: begin
					if (torch_pin_on) begin
						level_nxt = lfc_pkg::LVL_TORCH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			level_r <= lfc_pkg::LVL_OFF;
		end else begin
			level_r <= level_nxt;
		end
	end

	assign led_level = level_r;
	assign led_on = (level_r == lfc_pkg::LVL_FLASH) ||
		(level_r == lfc_pkg::LVL_TORCH);

	// ****************************************************************
	// Fault detection
	// ****************************************************************
	lfc_timer #(.W(16)) u_led_dg (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(led_on),
		.limit(16'(LED_DLY_CYC)),
		.done(led_dg)
	);

	lfc_timer #(.W(16)) u_vout_dg (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(led_on),
		.limit(16'(VOUT_DLY_CYC)),
		.done(vout_dg)
	);

	assign led_fault = led_on && ((led_dg && (led_low || ovp_trip)) ||
		(vout_dg && vout_low));
	assign ntc_trip = en_r[lfc_pkg::EN_NTC] && ntc_below &&
		(level_r != lfc_pkg::LVL_OFF);
	assign uvlo_trip = input_voltage_flash_monitor_r[lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE] && vin_uvlo;

	always_comb begin
		flag_set = 8'h00;
		flag_set[lfc_pkg::FLG_TO] = to_done;
		flag_set[lfc_pkg::FLG_TSD] = die_hot;
		flag_set[lfc_pkg::FLG_LED] = led_fault;
		flag_set[lfc_pkg::FLG_NTC] = ntc_trip;
		flag_set[lfc_pkg::FLG_TX] = tx_act && flash_act;
		flag_set[lfc_pkg::FLG_UVLO] = uvlo_trip;
		flag_set[lfc_pkg::FLG_INPUT_VOLTAGE_FLASH_MONITOR] = input_voltage_flash_monitor_evt;
	end

	assign lock_set = |(flag_set & lfc_pkg::FLG_LOCK_MASK);

	// A fault in the clearing cycle keeps its flag; TSD, LED, NTC and UVLO faults also keep the lock
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			flags_r <= 8'h00;
			lock_r <= 1'b0;
		end else begin
			flags_r <= (flags_r & {8{!clr}}) | flag_set;
			lock_r <= (lock_r && !clr) || lock_set;
		end
	end

	// ****************************************************************
	// Input voltage flash monitor
	// ****************************************************************
	assign filt_lim = 16'(FILT_BASE_CYC) << filt_sel_r;

	lfc_timer #(.W(16)) u_filt (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(vin_below_low),
		.limit(filt_lim),
		.done(filt_done)
	);

	lfc_input_voltage_flash_monitor u_input_voltage_flash_monitor (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mode(lfc_pkg::lfc_input_monitor_mode_t'(input_voltage_flash_monitor_r[lfc_pkg::INPUT_MONITOR_MODE_LSB +: 2])),
		.flash_act(flash_act),
		.ramp_busy(ramp_busy),
		.below_low(vin_below_low),
		.above_rec(vin_above_recovery),
		.filt_done(filt_done),
		.low_evt(input_voltage_flash_monitor_evt),
		.ramp_hold(ramp_hold),
		.ramp_down(ramp_down),
		.ramp_up(ramp_up)
	);

	assign input_voltage_flash_monitor_low_sel = input_voltage_flash_monitor_r[lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_THR_LSB +: 3];
	assign input_voltage_flash_monitor_hyst_sel = input_voltage_flash_monitor_r[lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_HYST_LSB +: 2];
	assign ntc_thr_sel = ntc_r[lfc_pkg::NTC_THR_LSB +: 3];
	assign ntc_cur_sel = ntc_r[lfc_pkg::NTC_CUR_LSB +: 2];
	assign curlim_sel = feat_r[lfc_pkg::FEAT_CL_LSB +: 2];

	// ****************************************************************
	// Converter control
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			conv_en <= 1'b0;
			nfet_off <= 1'b1;
			charge_end <= 1'b0;
			pfet_cs <= 1'b0;
			ntc_power <= 1'b0;
			standby <= 1'b1;
		end else begin
			conv_en <= level_nxt != lfc_pkg::LVL_OFF;
			nfet_off <= (level_nxt == lfc_pkg::LVL_OFF) || ovp_trip ||
				vout_low;
			charge_end <= curlim_trip;
			pfet_cs <= (level_nxt != lfc_pkg::LVL_OFF) && vout_low;
			ntc_power <= en_r[lfc_pkg::EN_NTC] &&
				(level_nxt != lfc_pkg::LVL_OFF);
			standby <= lock_r || lock_set;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	property p_tx_torch;
		flash_act && !to_done && !lock_r && !ntc_trip && tx_act &&
			cfg_r[lfc_pkg::CFG_TX_TORCH] |=> led_level == lfc_pkg::LVL_TORCH;
	endproperty
	a_tx_torch: assert property (p_tx_torch)
		else $error("sync active in flash did not give torch level");

	sequence s_tx_release;
		led_level == lfc_pkg::LVL_TORCH ##0 flash_act && !tx_act &&
			!to_done && !lock_r && !ntc_trip;
	endsequence
	property p_tx_restore;
		s_tx_release |=> led_level == lfc_pkg::LVL_FLASH;
	endproperty
	a_tx_restore: assert property (p_tx_restore)
		else $error("flash level not restored after sync release");

	property p_to_off;
		to_done |=> led_level == lfc_pkg::LVL_OFF &&
			en_r[1:0] == lfc_pkg::MODE_STBY && flags_r[lfc_pkg::FLG_TO];
	endproperty
	a_to_off: assert property (p_to_off)
		else $error("time-out did not turn LED off and clear modes");

	property p_tx_disabled;
		!en_r[lfc_pkg::EN_TX] && flash_act && !to_done && !ntc_trip
			&& !lock_r |=> led_level == lfc_pkg::LVL_FLASH;
	endproperty
	a_tx_disabled: assert property (p_tx_disabled)
		else $error("disabled sync input changed flash level");

	property p_input_voltage_flash_monitor_flag;
		$rose(vin_below_low) |=> flags_r[lfc_pkg::FLG_INPUT_VOLTAGE_FLASH_MONITOR];
	endproperty
	a_input_voltage_flash_monitor_flag: assert property (p_input_voltage_flash_monitor_flag)
		else $error("monitor flag not set on low crossing");

	property p_lock;
		lock_r |-> (en_r & lfc_pkg::EN_LOCK_MASK) == 8'h00 && standby ##1
			(lock_r || $past(clr));
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked enable bits not held at zero");

	property p_latch;
		flags_r[lfc_pkg::FLG_LED] && !clr |=> flags_r[lfc_pkg::FLG_LED];
	endproperty
	a_latch: assert property (p_latch)
		else $error("LED fault flag dropped without flags read");

	sequence s_flags_read;
		rd_pend_r && reg_rd_end && flag_set == 8'h00;
	endsequence
	property p_read_clear;
		s_flags_read |=> flags_r == 8'h00 && !lock_r;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("flags read did not clear flags and lock");

	property p_ovp;
		ovp_trip && !wr_en && !lock_set && !to_done |=>
			nfet_off && en_r[1:0] == $past(en_r[1:0]);
	endproperty
	a_ovp: assert property (p_ovp)
		else $error("overvoltage did not open switch or changed modes");

	property p_vout_cs;
		vout_low && level_nxt != lfc_pkg::LVL_OFF |=> pfet_cs && nfet_off;
	endproperty
	a_vout_cs: assert property (p_vout_cs)
		else $error("low output did not start current source mode");

	property p_uvlo_off;
		!input_voltage_flash_monitor_r[lfc_pkg::INPUT_VOLTAGE_FLASH_MONITOR_UNDERVOLTAGE_LOCKOUT_ENABLE] && !flags_r[lfc_pkg::FLG_UVLO]
			|=> !flags_r[lfc_pkg::FLG_UVLO];
	endproperty
	a_uvlo_off: assert property (p_uvlo_off)
		else $error("undervoltage flagged while lockout disabled");

	property p_tsd;
		die_hot |=> flags_r[lfc_pkg::FLG_TSD] && lock_r && standby &&
			en_r[1:0] == lfc_pkg::MODE_STBY ##1 led_level == lfc_pkg::LVL_OFF;
	endproperty
	a_tsd: assert property (p_tsd)
		else $error("die overheat did not force standby");

endmodule

// [verification/lfc_host.sv]
// Host model that drives the supervisor register port.
`timescale 1ns/1ps
module lfc_host (
	// Clock
	input wire logic ref_clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_rd_end,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_rd_end = 1'b0;
	end
	// Mode writes are only issued once the previous flash has ended
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		v = reg_rdata;
		reg_rd_end = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd_end = 1'b0;
	endtask
endmodule

// [verification/led_flash_mode_fault_control_bench.sv]
// Self-checking bench for the flash mode and fault supervisor.
`timescale 1ns/1ps
module led_flash_mode_fault_control_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, reg_rd_end, standby, nfet_off, charge_end;
	logic ramp_hold, ramp_down, ramp_up, ntc_power, conv_en, pfet_cs;
	logic [2:0] input_voltage_flash_monitor_low_sel, ntc_thr_sel;
	logic [1:0] input_voltage_flash_monitor_hyst_sel, ntc_cur_sel, curlim_sel;
	logic sb = 1'b0, ti = 1'b0, tx = 1'b0, lo = 1'b0, up = 1'b0;
	logic uv = 1'b0, hot = 1'b0, ntc = 1'b0, ovp = 1'b0, cl = 1'b0;
	logic vo = 1'b0, ll = 1'b0, rb = 1'b0;
	lfc_pkg::lfc_level_t led_level;
	int errors = 0;
	int check_count = 0;
	logic [7:0] ra [7] = '{8'h01, 8'h02, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h03};
	logic [7:0] rv [7] = '{8'h80, 8'h12, 8'h78, 8'h1F, 8'h40, 8'h00, 8'h00};

	always #20 ref_clk = ~ref_clk;

	lfc_host host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rd_end, .reg_rdata);
	lfc_top #(.TO_STEP_CYC(20), .LED_DLY_CYC(8), .VOUT_DLY_CYC(16),
		.FILT_BASE_CYC(4)) uut (.ref_clk, .nrst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rd_end, .reg_rdata, .strobe_in(sb),
		.torch_in(ti), .tx_in(tx), .vin_below_low(lo),
		.vin_above_recovery(up), .vin_uvlo(uv), .die_hot(hot),
		.ntc_below(ntc), .ovp_trip(ovp), .curlim_trip(cl), .vout_low(vo),
		.led_low(ll), .ramp_busy(rb), .led_level, .ramp_hold,
		.ramp_down, .ramp_up, .ntc_power, .standby, .conv_en,
		.nfet_off, .charge_end, .pfet_cs, .input_voltage_flash_monitor_low_sel,
		.input_voltage_flash_monitor_hyst_sel, .ntc_thr_sel, .ntc_cur_sel, .curlim_sel);

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk($sformatf("register %h", a), e, d);
	endtask
	task automatic lv(input lfc_pkg::lfc_level_t e);
		chk("led_level", {6'h00, e}, {6'h00, led_level});
	endtask
	task automatic bt(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (3000) @(posedge ref_clk);
		errors++;
		end_sim;
	end

	initial begin
		cyc(12);
		nrst = 1'b1;
		for (int i = 0; i < 7; i++) begin
			rc(ra[i], rv[i]);
		end
		chk("ntc_thr_sel", 8'h02, {5'h00, ntc_thr_sel});
		chk("ntc_cur_sel", 8'h02, {6'h00, ntc_cur_sel});
		$display("test reset values done");
		host.wr(8'h0A, 8'h43);
		cyc(2);
		lv(lfc_pkg::LVL_FLASH);
		tx = 1'b1;
		cyc(2);
		lv(lfc_pkg::LVL_TORCH);
		tx = 1'b0;
		cyc(2);
		lv(lfc_pkg::LVL_FLASH);
		tx = 1'b1;
		cyc(140);
		lv(lfc_pkg::LVL_TORCH);
		cyc(20);
		lv(lfc_pkg::LVL_OFF);
		rc(8'h0A, 8'h40);
		rc(8'h0B, 8'h11);
		rc(8'h0B, 8'h00);
		host.wr(8'h07, 8'h70);
		tx = 1'b0;
		host.wr(8'h0A, 8'h43);
		cyc(2);
		lv(lfc_pkg::LVL_TORCH);
		cyc(170);
		rc(8'h0B, 8'h11);
		$display("test flash and sync done");
		host.wr(8'h0A, 8'h02);
		cl = 1'b1;
		cyc(2);
		bt("charge_end", 1'b1, charge_end);
		cl = 1'b0;
		lv(lfc_pkg::LVL_TORCH);
		hot = 1'b1;
		cyc(1);
		hot = 1'b0;
		bt("standby", 1'b1, standby);
		rc(8'h0A, 8'h00);
		host.wr(8'h0A, 8'h02);
		rc(8'h0A, 8'h00);
		rc(8'h0B, 8'h02);
		cyc(2);
		bt("standby", 1'b0, standby);
		$display("test thermal lock done");
		host.wr(8'h01, 8'h00);
		uv = 1'b1;
		cyc(3);
		uv = 1'b0;
		bt("standby", 1'b0, standby);
		host.wr(8'h01, 8'h80);
		uv = 1'b1;
		cyc(1);
		uv = 1'b0;
		rc(8'h0B, 8'h20);
		cyc(2);
		$display("test undervoltage done");
		host.wr(8'h08, 8'h18);
		host.wr(8'h01, 8'hEB);
		chk("input_voltage_flash_monitor_low_sel", 8'h03, {5'h00, input_voltage_flash_monitor_low_sel});
		chk("input_voltage_flash_monitor_hyst_sel", 8'h01, {6'h00, input_voltage_flash_monitor_hyst_sel});
		chk("curlim_sel", 8'h03, {6'h00, curlim_sel});
		host.wr(8'h0A, 8'h0B);
		lo = 1'b1;
		cyc(2);
		bt("ntc_power", 1'b1, ntc_power);
		bt("ramp_down", 1'b0, ramp_down);
		cyc(4);
		bt("ramp_down", 1'b1, ramp_down);
		lo = 1'b0;
		up = 1'b1;
		cyc(1);
		bt("ramp_up", 1'b1, ramp_up);
		bt("ramp_down", 1'b0, ramp_down);
		up = 1'b0;
		cyc(20);
		bt("conv_en", 1'b0, conv_en);
		rc(8'h0B, 8'h41);
		host.wr(8'h01, 8'hA0);
		host.wr(8'h0A, 8'h23);
		lo = 1'b1;
		rb = 1'b1;
		cyc(2);
		lv(lfc_pkg::LVL_OFF);
		sb = 1'b1;
		cyc(6);
		lv(lfc_pkg::LVL_FLASH);
		bt("ramp_hold", 1'b1, ramp_hold);
		sb = 1'b0;
		lo = 1'b0;
		rb = 1'b0;
		cyc(20);
		rc(8'h0A, 8'h20);
		rc(8'h0B, 8'h41);
		$display("test input monitor and trigger done");
		host.wr(8'h0A, 8'h0B);
		ntc = 1'b1;
		cyc(2);
		lv(lfc_pkg::LVL_TORCH);
		cyc(1);
		lv(lfc_pkg::LVL_OFF);
		ntc = 1'b0;
		rc(8'h0A, 8'h08);
		rc(8'h0B, 8'h08);
		$display("test thermistor done");
		host.wr(8'h0A, 8'h02);
		ovp = 1'b1;
		cyc(3);
		bt("nfet_off", 1'b1, nfet_off);
		bt("standby", 1'b0, standby);
		vo = 1'b1;
		cyc(1);
		bt("pfet_cs", 1'b1, pfet_cs);
		vo = 1'b0;
		cyc(10);
		ovp = 1'b0;
		bt("standby", 1'b1, standby);
		rc(8'h0B, 8'h04);
		$display("test led fault done");
		end_sim;
	end
endmodule
